// ### core/pngc_pkg.sv
// shared constants and carrier types of the partner next-page and gigabit control bank
// assumes a single clock domain; every consumer names items as pngc_pkg::name
package pngc_pkg;

    // register index inside a port block; byte address is four times the full index
    localparam logic [11:0] NPR_IDX        = 12'h110;
    localparam logic [11:0] GCR_IDX        = 12'h112;
    // basic control lives outside this bank; software sets it up before a test code
    localparam logic [11:0] BCR_IDX        = 12'h100;
    localparam logic [15:0] BCR_TEST_SETUP = 16'h0140;
    // port number sits in index bits 13:12, first port is 1
    localparam int          PORT_IDX_LSB   = 12;
    localparam int          IDX_WIDTH      = 14;
    localparam int          ADDR_IDX_LSB   = 2;

    // gigabit control field positions
    localparam int          GC_TEST_MSB    = 15;
    localparam int          GC_TEST_LSB    = 13;
    localparam int          GC_MS_EN_BIT   = 12;
    localparam int          GC_MS_VAL_BIT  = 11;
    localparam int          GC_STORE_LSB   = 11;

    // partner page field positions
    localparam int          NP_MORE_BIT    = 15;

    // values after reset
    localparam logic [15:0] NP_RESET       = 16'h0000;
    localparam logic [2:0]  TEST_RESET     = 3'h0;
    localparam logic        MS_EN_RESET    = 1'b0;
    localparam logic        MS_VAL_RESET   = 1'b0;

    // transmitter test codes
    localparam logic [2:0]  TEST_NORMAL    = 3'h0;
    localparam logic [2:0]  TEST_WAVEFORM  = 3'h1;
    localparam logic [2:0]  TEST_JIT_MST   = 3'h2;
    localparam logic [2:0]  TEST_JIT_SLV   = 3'h3;
    localparam logic [2:0]  TEST_DISTORT   = 3'h4;

    localparam logic [3:0]  ALL_PAIRS      = 4'hf;
    localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;

    // received next page, same layout as the partner register
    typedef struct packed {
        logic        more_pages;
        logic        ack;
        logic        msg_page;
        logic        ack2;
        logic        toggle;
        logic [10:0] msg;
    } pngc_page_t;

    // gigabit control bits the bank keeps
    typedef struct packed {
        logic [2:0] test_sel;
        logic       ms_en;
        logic       ms_val;
    } pngc_gc_t;

    // what the transmitter and negotiation logic see
    typedef struct packed {
        logic [2:0] test_code;
        logic [3:0] pair_en;
        logic       ms_manual;
        logic       ms_master;
    } pngc_ctrl_t;

    // result of an address decode
    typedef struct packed {
        logic       hit;
        logic       is_gc;
        logic [1:0] port;
    } pngc_dec_t;

endpackage

// ### core/pngc_port.sv
// one port's partner next-page register and gigabit control register
// assumes write strobes and the received page come from logic on the same clock
`timescale 1ns/100ps

module pngc_port (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               rst,
    // register writes
    input  wire logic               wr_np,
    input  wire logic               wr_gc,
    input  wire logic [15:0]        wr_data,
    // received page
    input  wire logic               page_valid,
    input  wire pngc_pkg::pngc_page_t page_word,
    // register contents and derived control
    output pngc_pkg::pngc_page_t    partner,
    output pngc_pkg::pngc_gc_t      gc,
    output pngc_pkg::pngc_ctrl_t    ctrl
);

    pngc_pkg::pngc_page_t next_partner;
    pngc_pkg::pngc_gc_t   next_gc;
    pngc_pkg::pngc_ctrl_t next_ctrl;
    logic                 legal;
    logic [2:0]           wr_code;

    always_comb begin
        next_partner = partner;
        // a page arriving with a software write wins, the partner view must stay true
        if (page_valid) begin
            next_partner = page_word;
        end else if (wr_np) begin
            next_partner.more_pages = wr_data[pngc_pkg::NP_MORE_BIT];
        end
        next_gc = gc;
        if (wr_gc) begin
            next_gc = pngc_pkg::pngc_gc_t'(wr_data[15:pngc_pkg::GC_STORE_LSB]);
        end
        legal = (next_gc.test_sel >= pngc_pkg::TEST_WAVEFORM) &&
                (next_gc.test_sel <= pngc_pkg::TEST_DISTORT);
        // reserved codes leave the transmitter in normal operation
        next_ctrl.test_code = legal ? next_gc.test_sel : pngc_pkg::TEST_NORMAL;
        next_ctrl.pair_en   = legal ? pngc_pkg::ALL_PAIRS : 4'h0;
        next_ctrl.ms_manual = next_gc.ms_en;
        next_ctrl.ms_master = next_gc.ms_en & next_gc.ms_val;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            partner <= pngc_pkg::NP_RESET;
            gc      <= '{pngc_pkg::TEST_RESET, pngc_pkg::MS_EN_RESET, pngc_pkg::MS_VAL_RESET};
            ctrl    <= '0;
        end else begin
            partner <= next_partner;
            gc      <= next_gc;
            ctrl    <= next_ctrl;
        end
    end

    assign wr_code = wr_data[pngc_pkg::GC_TEST_MSB:pngc_pkg::GC_TEST_LSB];

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    page_load_a:   assert property (page_valid |=> partner == $past(page_word))
        else $error("received page not loaded");
    page_wins_a:   assert property (page_valid && wr_np |=>
                                    partner.more_pages == $past(page_word.more_pages))
        else $error("software write beat received page");
    more_write_a:  assert property (wr_np && !page_valid |=>
                                    partner.more_pages == $past(wr_data[pngc_pkg::NP_MORE_BIT]) &&
                                    $stable(partner.msg))
        else $error("more-pages write wrong");
    np_hold_a:     assert property (!page_valid && !wr_np |=> $stable(partner))
        else $error("partner register changed without cause");
    reserved_a:    assert property (gc.test_sel > pngc_pkg::TEST_DISTORT |->
                                    ctrl.pair_en == 4'h0 && ctrl.test_code == pngc_pkg::TEST_NORMAL)
        else $error("reserved test code drove transmitter");
    test_pairs_a:  assert property (
                                    wr_gc && wr_code inside {[pngc_pkg::TEST_WAVEFORM:pngc_pkg::TEST_DISTORT]} |=>
                                    ctrl.pair_en == pngc_pkg::ALL_PAIRS && ctrl.test_code == $past(wr_code))
        else $error("test mode not on all pairs");
    ms_ignore_a:   assert property (!gc.ms_en |-> !ctrl.ms_master && !ctrl.ms_manual)
        else $error("manual value used while disabled");
    ms_follow_a:   assert property (gc.ms_en |-> ctrl.ms_manual && ctrl.ms_master == gc.ms_val)
        else $error("manual role not followed");

endmodule

// ### core/pngc_top.sv
// register bank for the partner next page and gigabit control of each copper port
// assumes an AHB-Lite master on clk with this slave's hreadyout as hready,
// and a negotiation engine on clk that pulses page_valid per received next page
//
// Implementation choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/100ps

// How it works
// - Bit 15 of the partner register shows whether more next pages follow (1) or the page was the last (0).
// - Bit 14 of the partner register reads 1 when the partner acknowledged receipt of a link word.
// - Bit 13 tells message page from unformatted page and bits 10:0 hold the received message field.
// - Bit 12 of the partner register reads 1 when the partner can act on the information.
// - Bit 11 of the partner register reads 1 when the previous transmitted toggle was zero.
// - Control bits 15:13 pick normal, waveform, master jitter, slave jitter or distortion test, resetting to 000.
// - Codes 101, 110 and 111 are reserved and drive no test operation.
// - A selected test mode sends its waveform on all four pairs with no partner needed.
// - Control bit 12, reset 0, enables manual master/slave configuration; clear means negotiated roles.
// - The manual value in bit 11, reset 0, is ignored while bit 12 is clear.
// - With manual configuration on, value 1 makes the port master and 0 makes it slave.
module pngc_top #(
    parameter int NUM_PORTS = 2
) (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst,
    // ahb-lite slave
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic                      hreadyout,
    output logic                      hresp,
    output logic [31:0]               hrdata,
    // received next pages from negotiation
    input  wire logic                 page_valid [NUM_PORTS],
    input  wire pngc_pkg::pngc_page_t page_word  [NUM_PORTS],
    // transmitter and role control per port
    output pngc_pkg::pngc_ctrl_t      port_ctrl  [NUM_PORTS]
);

    // the port field is two bits and port 0 does not exist
    if (NUM_PORTS < 1 || NUM_PORTS > 3) begin : g_bad_ports
        $error("NUM_PORTS must be 1 to 3");
    end

    // full index is kept so both port and register offset are checked
    function automatic pngc_pkg::pngc_dec_t pngc_decode(input logic [31:0] addr);
        logic [pngc_pkg::IDX_WIDTH-1:0] idx;
        logic [1:0]                     prt;
        pngc_pkg::pngc_dec_t            d;
        idx     = addr[pngc_pkg::ADDR_IDX_LSB +: pngc_pkg::IDX_WIDTH];
        prt     = idx[pngc_pkg::PORT_IDX_LSB +: 2];
        d.port  = prt;
        d.is_gc = (idx[11:0] == pngc_pkg::GCR_IDX);
        d.hit   = (addr[31:16] == 16'h0000) && (addr[1:0] == 2'h0) &&
                  (prt != 2'h0) && (32'(prt) <= NUM_PORTS) &&
                  (idx[11:0] == pngc_pkg::NPR_IDX || idx[11:0] == pngc_pkg::GCR_IDX);
        return d;
    endfunction

    // bus state
    logic                 wr_pend;
    logic                 rd_pend;
    pngc_pkg::pngc_dec_t  wr_dec;
    pngc_pkg::pngc_dec_t  rd_dec;
    logic                 next_wr_pend;
    logic                 next_rd_pend;
    pngc_pkg::pngc_dec_t  next_wr_dec;
    pngc_pkg::pngc_dec_t  next_rd_dec;
    logic                 next_hreadyout;
    logic [31:0]          next_hrdata;
    logic                 accept;
    pngc_pkg::pngc_dec_t  addr_dec;
    logic [15:0]          rd_word;
    logic [2:0]           wr_code;

    // per-port wiring
    logic                 wr_np      [NUM_PORTS];
    logic                 wr_gc      [NUM_PORTS];
    pngc_pkg::pngc_page_t partner    [NUM_PORTS];
    pngc_pkg::pngc_gc_t   gc         [NUM_PORTS];

    assign accept   = hsel && htrans[1] && hready;
    assign addr_dec = pngc_decode(haddr);
    assign wr_code  = hwdata[pngc_pkg::GC_TEST_MSB:pngc_pkg::GC_TEST_LSB];

    // writes complete in their data phase with no wait; reads take one wait state
    // so that a write in the data phase just before has landed before sampling
    always_comb begin
        next_wr_pend   = 1'b0;
        next_rd_pend   = 1'b0;
        next_wr_dec    = wr_dec;
        next_rd_dec    = rd_dec;
        next_hreadyout = 1'b1;
        next_hrdata    = hrdata;
        if (accept) begin
            if (hwrite) begin
                next_wr_pend = 1'b1;
                next_wr_dec  = addr_dec;
            end else begin
                next_rd_pend   = 1'b1;
                next_rd_dec    = addr_dec;
                next_hreadyout = 1'b0;
            end
        end
        if (rd_pend) begin
            // unmapped addresses and unused upper bits read as zero
            next_hrdata = rd_dec.hit ? {16'h0000, rd_word} : 32'h0000_0000;
        end
    end

    always_comb begin
        rd_word = 16'h0000;
        for (int i = 0; i < NUM_PORTS; i++) begin
            if (rd_dec.hit && 32'(rd_dec.port) == i + 1) begin
                // gigabit control bits below 11 are not held here and read zero
                rd_word = rd_dec.is_gc ? {gc[i], 11'h000} : partner[i];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_pend   <= 1'b0;
            rd_pend   <= 1'b0;
            wr_dec    <= '0;
            rd_dec    <= '0;
            hreadyout <= 1'b1;
            hrdata    <= 32'h0000_0000;
        end else begin
            wr_pend   <= next_wr_pend;
            rd_pend   <= next_rd_pend;
            wr_dec    <= next_wr_dec;
            rd_dec    <= next_rd_dec;
            hreadyout <= next_hreadyout;
            hrdata    <= next_hrdata;
        end
    end

    // this slave never signals an error, unmapped accesses just read zero
    always_ff @(posedge clk) begin
        if (rst) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end

    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        logic sel;
        assign sel      = wr_pend && wr_dec.hit && (32'(wr_dec.port) == p + 1);
        assign wr_np[p] = sel && !wr_dec.is_gc;
        assign wr_gc[p] = sel && wr_dec.is_gc;

        pngc_port u_port (
            .clk        (clk),
            .rst        (rst),
            .wr_np      (wr_np[p]),
            .wr_gc      (wr_gc[p]),
            .wr_data    (hwdata[15:0]),
            .page_valid (page_valid[p]),
            .page_word  (page_word[p]),
            .partner    (partner[p]),
            .gc         (gc[p]),
            .ctrl       (port_ctrl[p])
        );

        // port-level checks that span the bus and the bank
        gc_write_a:   assert property (@(posedge clk) disable iff (rst)
                          wr_gc[p] |=> gc[p].test_sel == $past(wr_code) &&
                                       gc[p].ms_en == $past(hwdata[pngc_pkg::GC_MS_EN_BIT]) &&
                                       gc[p].ms_val == $past(hwdata[pngc_pkg::GC_MS_VAL_BIT]))
            else $error("gigabit control write lost");
        gc_hold_a:    assert property (@(posedge clk) disable iff (rst)
                          !wr_gc[p] |=> $stable(gc[p]))
            else $error("gigabit control changed without write");
        ctrl_reset_a: assert property (@(posedge clk)
                          $fell(rst) |-> port_ctrl[p].test_code == pngc_pkg::TEST_NORMAL &&
                                         !port_ctrl[p].ms_manual && port_ctrl[p].pair_en == 4'h0)
            else $error("control not normal after reset");
        negotiated_a: assert property (@(posedge clk) disable iff (rst)
                          wr_gc[p] && !hwdata[pngc_pkg::GC_MS_EN_BIT] |=>
                          !port_ctrl[p].ms_manual && !port_ctrl[p].ms_master)
            else $error("manual role kept after disable");
        manual_mst_a: assert property (@(posedge clk) disable iff (rst)
                          wr_gc[p] && hwdata[pngc_pkg::GC_MS_EN_BIT] |=>
                          port_ctrl[p].ms_master == $past(hwdata[pngc_pkg::GC_MS_VAL_BIT]))
            else $error("manual value not applied");
        // reads answer with what the bank held during the wait cycle
        np_read_a:    assert property (@(posedge clk) disable iff (rst)
                          accept && !hwrite && addr_dec.hit && !addr_dec.is_gc &&
                          32'(addr_dec.port) == p + 1 |=> ##1 hrdata[15:0] == $past(partner[p]))
            else $error("partner register read wrong on port");
        gc_read_a:    assert property (@(posedge clk) disable iff (rst)
                          accept && !hwrite && addr_dec.hit && addr_dec.is_gc &&
                          32'(addr_dec.port) == p + 1 |=> ##1 hrdata[15:0] == {$past(gc[p]), 11'h000})
            else $error("gigabit control read wrong");
        pairs_all_a:  assert property (@(posedge clk) disable iff (rst)
                          port_ctrl[p].test_code != pngc_pkg::TEST_NORMAL |->
                          port_ctrl[p].pair_en == pngc_pkg::ALL_PAIRS)
            else $error("test mode missing pairs");
        code_legal_a: assert property (@(posedge clk) disable iff (rst)
                          port_ctrl[p].test_code <= pngc_pkg::TEST_DISTORT)
            else $error("reserved code reached transmitter");
    end

    // bus protocol checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence rd_taken_s;
        accept && !hwrite;
    endsequence

    sequence rd_wait_s;
        !hreadyout ##1 hreadyout;
    endsequence

    sequence wr_taken_s;
        accept && hwrite;
    endsequence

    read_wait_a:  assert property (rd_taken_s |=> rd_wait_s)
        else $error("read did not take exactly one wait state");
    write_fast_a: assert property (wr_taken_s |=> hreadyout)
        else $error("write data phase stalled");
    unmapped_a:   assert property (rd_taken_s ##0 !addr_dec.hit |=> ##1 hrdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    upper_zero_a: assert property (hreadyout |-> hrdata[31:16] == 16'h0000 && !hresp)
        else $error("upper read bits or response wrong");
    page_read_a:  assert property (rd_taken_s ##0 addr_dec.hit && !addr_dec.is_gc &&
                                   addr_dec.port == 2'h1 && !page_valid[0]
                                   |=> ##1 hrdata[15:0] == $past(partner[0]))
        else $error("partner register read wrong");
    one_wait_a:   assert property (!hreadyout |=> hreadyout)
        else $error("read wait longer than one cycle");
    bus_reset_a:  assert property ($fell(rst) |-> hreadyout && !hresp && hrdata == 32'h0000_0000)
        else $error("bus outputs not idle after reset");

endmodule

// ### verif/pngc_lp_model.sv
// link partner model: hands each received next page to the bank as one pulse
// assumes the bank samples page_word at the rising edge where page_valid is high
`timescale 1ns/100ps

module pngc_lp_model #(
    parameter int NUM_PORTS = 2
) (
    // clock
    input  wire logic            clk,
    // received pages
    output logic                 page_valid [NUM_PORTS],
    output pngc_pkg::pngc_page_t page_word  [NUM_PORTS]
);
    initial begin
        for (int i = 0; i < NUM_PORTS; i++) begin
            page_valid[i] = 1'b0;
            page_word[i]  = 16'h0000;
        end
    end

    task automatic send(input int p, input pngc_pkg::pngc_page_t w);
        @(posedge clk);
        page_valid[p] <= 1'b1;
        page_word[p]  <= w;
        @(posedge clk);
        page_valid[p] <= 1'b0;
        // word means nothing outside the pulse; flip it so a stale copy never passes
        page_word[p]  <= ~w;
    endtask
endmodule

// ### verif/tb_phy_next_page_and_gbit_control.sv
// self-checking bench of the partner page and gigabit control bank
// assumes the bank answers on ahb-lite with 0 wait writes and 1 wait reads
`timescale 1ns/100ps

module tb_phy_next_page_and_gbit_control;
    logic                 clk, rst, hsel, hwrite, hready, hreadyout, hresp;
    logic [1:0]           htrans;
    logic [2:0]           hsize;
    logic [31:0]          haddr, hwdata, hrdata;
    logic                 page_valid [2];
    pngc_pkg::pngc_page_t page_word  [2];
    pngc_pkg::pngc_ctrl_t port_ctrl  [2];
    int                   bad_count, n_checks, seed;
    logic [31:0]          exp_q[$];
    string                name_q[$];
    logic                 rd_dp;
    logic [15:0]          w, gcv [2];
    logic [2:0]           c;
    logic                 en, val;

    assign hready = hreadyout;

    pngc_top #(.NUM_PORTS(2)) dut_u (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .page_valid(page_valid), .page_word(page_word),
        .port_ctrl(port_ctrl));

    pngc_lp_model #(.NUM_PORTS(2)) lp_u (.clk(clk), .page_valid(page_valid), .page_word(page_word));

    always #25 clk = ~clk;

    task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    function automatic logic [31:0] np_a(input int p);
        return 32'(p) * 32'h4000 + 32'(pngc_pkg::NPR_IDX) * 4;
    endfunction

    function automatic logic [31:0] gc_a(input int p);
        return 32'(p) * 32'h4000 + 32'(pngc_pkg::GCR_IDX) * 4;
    endfunction

    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= pngc_pkg::HTRANS_NONSEQ;
        haddr  <= a;
        hwrite <= wr;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] e, input string n);
        exp_q.push_back(e);
        name_q.push_back(n);
        bus(1'b0, a, $random(seed));
    endtask

    task automatic ctrl_chk(input int p, input logic [2:0] code, input logic me, input logic mv);
        logic act;
        act = (code >= 3'h1 && code <= 3'h4);
        @(negedge clk);
        check("port_ctrl", 32'(port_ctrl[p]), {23'h0, act ? code : 3'h0, act ? 4'hf : 4'h0, me, me & mv});
    endtask

    // read results land whenever the data phase ends; match them to the oldest note
    always @(posedge clk) begin
        if (rst) begin
            rd_dp = 1'b0;
        end else begin
            if (rd_dp && hreadyout === 1'b1) begin
                rd_dp = 1'b0;
                if (exp_q.size() == 0)
                    check("unexpected read", 32'h1, 32'h0);
                else
                    check(name_q.pop_front(), hrdata, exp_q.pop_front());
                check("hresp", {31'h0, hresp}, 32'h0);
            end
            if (hsel && htrans[1] && hready && !hwrite)
                rd_dp = 1'b1;
        end
    end

    initial begin
        #1000000;
        bad_count++;
        summarize();
    end

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        hsel = 1'b0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        haddr = 32'h0;
        hwdata = 32'h0;
        bad_count = 0;
        n_checks = 0;
        seed = 34536;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (int p = 0; p < 2; p++) begin
            rd(np_a(p + 1), 32'h0, "partner reset");
            rd(gc_a(p + 1), 32'h0, "gc reset");
            ctrl_chk(p, 3'h0, 1'b0, 1'b0);
        end
        // pages on alternating ports, then software moves only the more-pages bit
        for (int i = 0; i < 6; i++) begin
            w = 16'($random(seed));
            lp_u.send(i % 2, w);
            rd(np_a(i % 2 + 1), {16'h0, w}, "partner page");
        end
        bus(1'b1, np_a(2), 32'hffff_ffff);
        rd(np_a(2), {16'h0, 1'b1, w[14:0]}, "more pages set");
        bus(1'b1, np_a(2), 32'h0000_0000);
        rd(np_a(2), {16'h0, 1'b0, w[14:0]}, "more pages clear");
        // basic control forced to 1000 Mbps first; it is not part of this bank
        for (int p = 1; p <= 2; p++)
            bus(1'b1, 32'(p) * 32'h4000 + 32'(pngc_pkg::BCR_IDX) * 4, 32'(pngc_pkg::BCR_TEST_SETUP));
        // every test code with manual role bits, random junk in unused bits
        for (int i = 0; i < 32; i++) begin
            c = i[2:0];
            en = i[3];
            val = i[1] ^ i[0];
            gcv[i / 16] = {c, en, val, 11'h0};
            bus(1'b1, gc_a(i / 16 + 1), {16'($random(seed)), c, en, val, 11'($random(seed))});
            ctrl_chk(i / 16, c, en, val);
            rd(gc_a(i / 16 + 1), {16'h0, gcv[i / 16]}, "gc readback");
        end
        // unmapped places: next word, third port, misaligned
        bus(1'b1, gc_a(1) + 32'h4, 32'h0000_ffff);
        bus(1'b1, gc_a(3), 32'h0000_ffff);
        bus(1'b1, gc_a(1) + 32'h1, 32'h0000_ffff);
        rd(gc_a(1) + 32'h4, 32'h0, "unmapped next");
        rd(gc_a(3), 32'h0, "unmapped port");
        rd(gc_a(1), {16'h0, gcv[0]}, "gc untouched");
        rd(gc_a(2), {16'h0, gcv[1]}, "gc untouched");
        // reset in mid-run clears everything again
        bus(1'b1, gc_a(1), 32'h0000_3800);
        ctrl_chk(0, 3'h1, 1'b1, 1'b1);
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        ctrl_chk(0, 3'h0, 1'b0, 1'b0);
        rd(gc_a(1), 32'h0, "gc after reset");
        rd(np_a(1), 32'h0, "partner after reset");
        repeat (3) @(posedge clk);
        check("pending reads", 32'(exp_q.size()), 32'h0);
        summarize();
    end
endmodule
